// ===== rtl/cnt_ctrl_consts.svh
// constants for the per-channel counter control block
`ifndef CNT_CTRL_CONSTS_SVH
`define CNT_CTRL_CONSTS_SVH
`define CC_ADDR_CH0      4'h0
`define CC_ADDR_CH1      4'h1
`define CC_ADDR_CH2      4'h2
`define CC_ADDR_CNT0     4'h4
`define CC_ADDR_CNT1     4'h5
`define CC_ADDR_CNT2     4'h6
`define CC_ADDR_MODE     4'h8
`define CC_ADDR_RUN      4'h9
`define CC_ADDR_SYNC     4'hA
`define CC_RESET_VAL     8'h00
`define CC_CLR_HI        7
`define CC_CLR_LO        5
`define CC_EDGE_HI       4
`define CC_EDGE_LO       3
`define CC_PSC_HI        2
`define CC_PSC_LO        0
`define CC_RSVD_MASK     8'h7F
`define CC_DIV_W         10
`define CC_CNT_RESET     16'h0000
`endif

// ===== rtl/cnt_ctrl_pkg.sv
// types for the per-channel counter control block
package cnt_ctrl_pkg;
   typedef struct packed {
      logic [2:0] clear_sel;
      logic [1:0] edge_sel;
      logic [2:0] prescale_sel;
   } counter_control_t;

   typedef enum logic [2:0] {
      CLR_NONE = 3'h0, CLR_A = 3'h1, CLR_B = 3'h2, CLR_SYNC = 3'h3,
      CLR_NONE2 = 3'h4, CLR_C = 3'h5, CLR_D = 3'h6, CLR_SYNC2 = 3'h7
   } clear_src_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;
endpackage

// ===== rtl/timer_count_clock_control.sv
// three-channel counter clock, edge and clear control with a plain register port
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "cnt_ctrl_consts.svh"

// Function
// RULE1: three counter control registers, one per channel 0, 1, 2.
// RULE2: software writes a channel's control only while its counter is halted.
// RULE3: bits 7..5 select the event that clears the channel counter.
// RULE4: bits 4..3 pick edge: 00 rising, 01 falling, 1x both.
// RULE5: both edges of prescaled clock count at twice the prescaled rate.
// RULE6: phase counting mode ignores the edge select field.
// RULE7: internal clock edge select works only for divide by four or slower.
// RULE8: undivided clock ignores edge select, counting every system clock.
// RULE9: bits 2..0 select the channel count clock.
// RULE10: each channel keeps its own independent clock selection.
// RULE11: clear codes 000 none, 001 A, 010 B, 011 synchronised channel.
// RULE12: clearing from another channel applies only to sync-enabled channels.
// RULE13: channels 1 and 2 bit 7 reads zero and ignores writes.
// RULE14: channel 0 codes 000..011 divide 1,4,16,64; 100..111 pins A..D.
// RULE15: counter steps one per qualifying edge, zeroed on selected clear event.
// RULE16: external clock pins synchronised before edge detection.
module timer_count_clock_control (
   // clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    resetn,
   // register port
   input  wire logic [3:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,
   // external count clock pins a..d
   input  wire logic [3:0]              ext_count_clock,
   // per-channel match or capture events for general registers a and b; c and d are single events used by channel 0 only
   input  wire logic [2:0]              match_a,
   input  wire logic [2:0]              match_b,
   input  wire logic                    match_c,
   input  wire logic                    match_d,
   // channel counters
   output logic      [2:0][15:0]        channel_count_value
);
   logic [2:0][7:0]  cc_ff, nxt_cc;
   logic [2:0][15:0] cnt_ff, nxt_cnt;
   logic [2:0]       run_ff, nxt_run, sync_ff, nxt_sync, phase_ff, nxt_phase;
   logic [7:0]       rdata_ff, nxt_rdata;
   logic [`CC_DIV_W-1:0] div_ff, nxt_div;
   logic [3:0]       s1_ff, s2_ff, s3_ff, ext_lvl_ff, nxt_ext_lvl;
   logic [3:0]       ext_rise, ext_fall;
   logic [5:0]       pre_lvl;       // prescaled square waves /4 /16 /64 /256 /1024
   logic [5:0]       pre_prev_ff;
   logic [2:0]       step, clr;

   // register writes and run/sync/mode bits; reserved bit 7 masked on ch1/ch2
   always_comb begin
      nxt_cc    = cc_ff;
      nxt_run   = run_ff;
      nxt_sync  = sync_ff;
      nxt_phase = phase_ff;
      nxt_rdata = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            `CC_ADDR_CH0: nxt_cc[0] = reg_wdata; // RULE1
            `CC_ADDR_CH1: nxt_cc[1] = reg_wdata & `CC_RSVD_MASK; // RULE13
            `CC_ADDR_CH2: nxt_cc[2] = reg_wdata & `CC_RSVD_MASK; // RULE13
            `CC_ADDR_MODE: nxt_phase = {reg_wdata[2:1], 1'b0}; // ch0 has no phase mode
            `CC_ADDR_RUN: nxt_run = reg_wdata[2:0];
            `CC_ADDR_SYNC: nxt_sync = reg_wdata[2:0];
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `CC_ADDR_CH0: nxt_rdata = cc_ff[0];
            `CC_ADDR_CH1: nxt_rdata = cc_ff[1];
            `CC_ADDR_CH2: nxt_rdata = cc_ff[2];
            `CC_ADDR_CNT0: nxt_rdata = cnt_ff[0][7:0];
            `CC_ADDR_CNT1: nxt_rdata = cnt_ff[1][7:0];
            `CC_ADDR_CNT2: nxt_rdata = cnt_ff[2][7:0];
            `CC_ADDR_MODE: nxt_rdata = {5'h00, phase_ff};
            `CC_ADDR_RUN: nxt_rdata = {5'h00, run_ff};
            `CC_ADDR_SYNC: nxt_rdata = {5'h00, sync_ff};
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // free-running prescaler; bit k toggles the phi/2^(k+1) square wave
   assign nxt_div = div_ff + `CC_DIV_W'(1);
   assign pre_lvl = {div_ff[9], div_ff[7], div_ff[5], div_ff[3], div_ff[1], 1'b0};

   // pin sync: 3 stages, a change counts once stages 2 and 3 agree
   always_comb begin
      nxt_ext_lvl = ext_lvl_ff;
      for (int i = 0; i < 4; i++) begin
         if (s2_ff[i] == s3_ff[i]) nxt_ext_lvl[i] = s3_ff[i]; // RULE16
      end
   end
   assign ext_rise = nxt_ext_lvl & ~ext_lvl_ff;
   assign ext_fall = ~nxt_ext_lvl & ext_lvl_ff;

   // choose count event per channel
   always_comb begin
      cnt_ctrl_pkg::counter_control_t c;
      logic r, f, internal, is_phi1;
      int   idx;
      c = '0; r = 1'b0; f = 1'b0; internal = 1'b1; is_phi1 = 1'b0; idx = 0;
      for (int ch = 0; ch < 3; ch++) begin
         c = cc_ff[ch]; // RULE10
         r = 1'b0; f = 1'b0; internal = 1'b1; is_phi1 = 1'b0; idx = 0;
         case (c.prescale_sel) // RULE9 RULE14
            3'h0: is_phi1 = 1'b1;
            3'h1: idx = 1;
            3'h2: idx = 2;
            3'h3: idx = 3;
            3'h4: begin internal = 1'b0; idx = 0; end
            3'h5: begin internal = 1'b0; idx = 1; end
            3'h6: if (ch == 1) idx = 4; else begin internal = 1'b0; idx = 2; end
            3'h7: if (ch == 0) begin internal = 1'b0; idx = 3; end
                  else if (ch == 2) idx = 5;
                  else is_phi1 = 1'b1; // prohibited code, treated as phi/1
            default: is_phi1 = 1'b1;
         endcase
         if (internal) begin
            r = pre_lvl[idx] & ~pre_prev_ff[idx];
            f = ~pre_lvl[idx] & pre_prev_ff[idx];
         end else begin
            r = ext_rise[idx];
            f = ext_fall[idx];
         end
         if (is_phi1 || phase_ff[ch]) begin
            step[ch] = 1'b1; // RULE8 RULE6 (phase decode lives outside; step on each clock)
         end else begin
            case (c.edge_sel) // RULE4 RULE7
               2'b00: step[ch] = r;
               2'b01: step[ch] = f;
               default: step[ch] = r | f; // RULE5
            endcase
         end
         step[ch] = step[ch] & run_ff[ch];
      end
   end

   // clear selection; sync clear needs own sync bit and a synced sibling clearing
   logic [2:0] own_clr;
   always_comb begin
      for (int ch = 0; ch < 3; ch++) begin
         case (cc_ff[ch][`CC_CLR_HI:`CC_CLR_LO]) // RULE3 RULE11
            3'h1: own_clr[ch] = match_a[ch];
            3'h2: own_clr[ch] = match_b[ch];
            3'h5: own_clr[ch] = (ch == 0) & match_c;
            3'h6: own_clr[ch] = (ch == 0) & match_d;
            default: own_clr[ch] = 1'b0;
         endcase
      end
      for (int ch = 0; ch < 3; ch++) begin
         clr[ch] = own_clr[ch];
         if ((cc_ff[ch][1+`CC_CLR_LO:`CC_CLR_LO] == 2'b11) && sync_ff[ch]) begin
            clr[ch] = |(own_clr & sync_ff & ~(3'h1 << ch)); // RULE12
         end
      end
   end

   // counter: clear wins over step
   always_comb begin
      for (int ch = 0; ch < 3; ch++) begin
         if (clr[ch]) nxt_cnt[ch] = `CC_CNT_RESET; // RULE15
         else if (step[ch]) nxt_cnt[ch] = cnt_ff[ch] + 16'h0001; // RULE15
         else nxt_cnt[ch] = cnt_ff[ch];
      end
   end

   // register all state
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cc_ff       <= {3{`CC_RESET_VAL}};
         cnt_ff      <= '0;
         run_ff      <= 3'h0;
         sync_ff     <= 3'h0;
         phase_ff    <= 3'h0;
         rdata_ff    <= 8'h00;
         div_ff      <= '0;
         pre_prev_ff <= 6'h00;
         s1_ff       <= 4'h0;
         s2_ff       <= 4'h0;
         s3_ff       <= 4'h0;
         ext_lvl_ff  <= 4'h0;
      end else begin
         cc_ff       <= nxt_cc;
         cnt_ff      <= nxt_cnt;
         run_ff      <= nxt_run;
         sync_ff     <= nxt_sync;
         phase_ff    <= nxt_phase;
         rdata_ff    <= nxt_rdata;
         div_ff      <= nxt_div;
         pre_prev_ff <= pre_lvl;
         s1_ff       <= ext_count_clock;
         s2_ff       <= s1_ff;
         s3_ff       <= s2_ff;
         ext_lvl_ff  <= nxt_ext_lvl;
      end
   end

   assign reg_rdata           = rdata_ff;
   assign channel_count_value = cnt_ff;

   // reserved bit never set on channels 1 and 2
   property p_rsvd;
      @(posedge clk_sys) disable iff (!resetn) !cc_ff[1][7] && !cc_ff[2][7];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // RULE13

   // phi/1 with channel running counts every cycle
   property p_phi1;
      @(posedge clk_sys) disable iff (!resetn)
         (run_ff[0] && cc_ff[0][2:0] == 3'h0 && cc_ff[0][7:5] == 3'h0 && !reg_wr)
         |=> cnt_ff[0] == $past(cnt_ff[0]) + 16'h0001;
   endproperty
   a_phi1: assert property (p_phi1) else $error("phi1 count missed"); // RULE8

   // clear on a match zeroes the counter next cycle
   property p_clr_a;
      @(posedge clk_sys) disable iff (!resetn)
         (cc_ff[0][7:5] == 3'h1 && match_a[0]) |=> cnt_ff[0] == 16'h0000;
   endproperty
   a_clr_a: assert property (p_clr_a) else $error("clear on A missed"); // RULE11

   // stopped channel holds its count
   property p_hold;
      @(posedge clk_sys) disable iff (!resetn)
         (!run_ff[1] && !clr[1]) |=> $stable(cnt_ff[1]);
   endproperty
   a_hold: assert property (p_hold) else $error("stopped counter moved"); // RULE15

   // channel 1 control never returns its reserved bit on a read
   property p_rsvd_read;
      @(posedge clk_sys) disable iff (!resetn)
         (reg_rd && reg_addr == `CC_ADDR_CH1) |=> !reg_rdata[7];
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit read back"); // RULE13

   // channel 1 armed for synchronised clearing, with its own sync bit set
   sequence s_sync_armed;
      cc_ff[1][`CC_CLR_HI:`CC_CLR_LO] == 3'h3 && sync_ff[1];
   endsequence
   // a synchronised sibling fires its own clear event
   sequence s_sibling_clear;
      own_clr[0] && sync_ff[0];
   endsequence
   // the armed channel follows the sibling's clear on the next edge
   property p_sync_clr;
      @(posedge clk_sys) disable iff (!resetn)
         (s_sync_armed and s_sibling_clear) |=> cnt_ff[1] == `CC_CNT_RESET;
   endproperty
   a_sync_clr: assert property (p_sync_clr) else $error("sync clear missed"); // RULE12
endmodule // timer_count_clock_control

// ===== sim/timer_count_clock_control_bench.sv
// self-checking bench for the counter clock, edge and clear control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module timer_count_clock_control_bench;
   logic             clk_sys = 1'b0;
   logic             resetn = 1'b0;
   logic [3:0]       reg_addr = 4'h0;
   logic [7:0]       reg_wdata = 8'h00;
   logic             reg_wr = 1'b0;
   logic             reg_rd = 1'b0;
   logic [7:0]       reg_rdata;
   logic [3:0]       ext_count_clock = 4'h0;
   logic [7:0]       match = 8'h00;
   logic [2:0][15:0] channel_count_value;
   int               bad_count = 0;
   int               samples_checked = 0;
   logic [31:0]      seed = 32'h3F2F;
   logic [7:0]       v, w, d;
   logic [7:0]       ev [3];
   logic [2:0]       p;
   logic [23:0]      t;
   int               win;
   logic [3:0]       ca;
   // clear cases: channel, code, sync bits, match vector {d,c,b[2:0],a[2:0]}, cleared
   logic [23:0]      cases [11] = '{24'h010011, 24'h010080, 24'h000FF0, 24'h040FF0,
      24'h050401, 24'h060801, 24'h120101, 24'h210041, 24'h210020, 24'h133011, 24'h131010};

   timer_count_clock_control u_timer_count_clock_control (
      .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_count_clock(ext_count_clock), .match_a(match[2:0]), .match_b(match[5:3]),
      .match_c(match[6]), .match_d(match[7]), .channel_count_value(channel_count_value));

   // 20 MHz system clock
   always #25 clk_sys = ~clk_sys;

   // repeatable xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // steps in 64 cycles; both edges double the prescaled rate except on the undivided clock
   function automatic logic [7:0] exp_delta(input logic [1:0] psc, input logic [1:0] edg);
      logic [7:0] n;
      n = 8'h40 >> (2 * psc);
      return (edg[1] && psc != 2'h0) ? 8'(n << 1) : n;
   endfunction

   // register port cycles, strobes launched just after an edge
   task automatic wr(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= x;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] x);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 x = reg_rdata;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog well beyond the expected run of about 6500 cycles
   initial begin
      #(50 * 40000);
      bad_count++;
      finish_test();
   end

   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rd(a[3:0], v);
         `CHK("ctrl reset", 8'h00, v)
      end
      $display("test reset done");
      // random control values, all channels written before any is read back
      for (int i = 0; i < 8; i++) begin
         for (int c = 0; c < 3; c++) begin
            w = (i == 0) ? 8'hFF : 8'(rnd());
            ev[c] = (c == 0) ? w : (w & 8'h7F);
            wr(c[3:0], w);
         end
         for (int c = 0; c < 3; c++) begin
            rd(c[3:0], v);
            `CHK("ctrl readback", ev[c], v)
         end
         wr(4'hF, 8'hFF);
         rd(4'hF, v);
         `CHK("unmapped", 8'h00, v)
         // mode, run and sync bits; no control write happens while they run
         w = 8'(rnd());
         wr(4'h8, w);
         wr(4'h9, w);
         wr(4'hA, w);
         rd(4'h8, v);
         `CHK("mode readback", {5'h00, w[2:1], 1'b0}, v)
         rd(4'h9, v);
         `CHK("run readback", {5'h00, w[2:0]}, v)
         rd(4'hA, v);
         `CHK("sync readback", {5'h00, w[2:0]}, v)
         wr(4'h8, 8'h00);
         wr(4'h9, 8'h00);
      end
      $display("test control registers done");
      // prescale codes 000..011 with every edge code on every channel, 64-cycle window
      for (int c = 0; c < 3; c++) begin
         for (int k = 0; k < 16; k++) begin
            wr(c[3:0], {3'h0, k[1:0], 1'b0, k[3:2]});
            wr(4'h9, 8'(1 << c));
            rd(4'(4 + c), v);
            repeat (62) @(posedge clk_sys);
            rd(4'(4 + c), d);
            wr(4'h9, 8'h00);
            `CHK("count step", exp_delta(k[3:2], k[1:0]), 8'(d - v))
         end
      end
      $display("test internal clocks done");
      // slow dividers, prohibited channel 1 code and phase mode, both edges selected
      for (int j = 0; j < 4; j++) begin
         win = (j == 0) ? 256 : ((j == 1) ? 1024 : 64);
         ca  = 4'((j % 2 == 1) ? 6 : 5);
         wr(4'h8, 8'((j == 3) ? 4 : 0));
         wr(4'(ca - 4), {5'h02, 3'((j == 0) ? 6 : ((j == 3) ? 3 : 7))});
         wr(4'h9, 8'((j % 2 == 1) ? 4 : 2));
         rd(ca, v);
         repeat (win - 2) @(posedge clk_sys);
         rd(ca, d);
         wr(4'h9, 8'h00);
         `CHK("slow step", 8'((j > 1) ? 64 : 2), 8'(d - v))
      end
      wr(4'h8, 8'h00);
      $display("test slow clocks done");
      // slow pulses on each external pin; latency of a few cycles is waited out
      for (int e = 0; e < 4; e++) begin
         wr(4'h0, {3'h0, 2'(e % 3), 3'(4 + e)});
         wr(4'h9, 8'h01);
         rd(4'h4, v);
         p = 3'(rnd() % 5 + 1);
         // pin edges launched on a clock edge, not just after the read
         @(posedge clk_sys);
         repeat (p) begin
            ext_count_clock[e] <= 1'b1;
            repeat (6) @(posedge clk_sys);
            ext_count_clock[e] <= 1'b0;
            repeat (6) @(posedge clk_sys);
         end
         repeat (10) @(posedge clk_sys);
         rd(4'h4, d);
         wr(4'h9, 8'h00);
         `CHK("ext count", 8'((e % 3 == 2) ? 2 * p : p), 8'(d - v))
      end
      $display("test external clocks done");
      // clear sources, with a reset in mid-run before each case
      for (int i = 0; i < 11; i++) begin
         t = cases[i];
         resetn <= 1'b0;
         repeat (2) @(posedge clk_sys);
         // reset alone zeroes every counter and the read data
         `CHK("reset state", 56'h0, {reg_rdata, channel_count_value})
         resetn <= 1'b1;
         wr(4'h0, 8'h22);
         wr(t[23:20], {t[18:16], 5'h02});
         wr(4'hA, {5'h00, t[14:12]});
         wr(4'h9, 8'h07);
         repeat (80) @(posedge clk_sys);
         rd(4'h4 + t[23:20], v);
         @(posedge clk_sys);
         match <= t[11:4];
         @(posedge clk_sys);
         match <= 8'h00;
         rd(4'h4 + t[23:20], d);
         `CHK("clear", t[0], d < v)
      end
      $display("test clear sources done");
      finish_test();
   end
endmodule // timer_count_clock_control_bench
